// [dma_strobe_pkg.sv]
// Package for the host-port DMA master strobe generator.
// Assumes a single 20 MHz system clock; no software-visible registers.
package dma_strobe_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int DELAY_SHORT = 2;
  localparam int DELAY_LONG = 4;
  localparam int ACK_LEAD_CYCLES = 2;
  localparam int ACK_TAIL_CYCLES = 2;
  localparam int COUNT_BASE = 2;
  localparam int EXTRA_BURST_MAX = 2;
  localparam int DELAY_SEL_BIT = 6;
  localparam int LOW_LSB = 0;
  localparam int HIGH_LSB = 3;
  localparam logic [7:0] TIMING_RESET = 8'h00;

  typedef struct packed {
    logic delay_long;
    logic [2:0] low_count;
    logic [2:0] high_count;
  } strobe_timing_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_DELAY = 3'b011,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b110,
    ST_TAIL = 3'b111
  } dma_state_t;
endpackage

// [dma_strobe_master.sv]
// Host-port DMA master: request/acknowledge handshake and data strobes.
// Assumes the core selects the strobe time base via time_tick_in.
`timescale 1ns/1ps
module dma_strobe_master #(
  parameter int DATA_W = 16
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [7:0] dma_timing_register_in,
  input wire logic burst_mode_in,
  input wire logic write_dir_in,
  input wire logic time_tick_in,
  input wire logic dma_request_in,
  input wire logic [DATA_W-1:0] write_data_in,
  input wire logic [DATA_W-1:0] data_bus_in,
  output logic dma_acknowledge_out,
  output logic dma_read_strobe_n_out,
  output logic dma_write_strobe_n_out,
  output logic [DATA_W-1:0] data_bus_out,
  output logic data_bus_oe_out,
  output logic [DATA_W-1:0] read_data_out,
  output logic read_valid_out
);
  dma_strobe_pkg::dma_state_t state, next_state;
  dma_strobe_pkg::strobe_timing_t timing, next_timing;
  logic [3:0] count, next_count;
  logic [1:0] extra, next_extra;
  logic req_s1, req_s2, req_s3, req_seen, next_req_seen;
  logic strobe, next_strobe, drive, next_drive;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  logic is_write, next_is_write;
  logic [DATA_W-1:0] wdata, next_wdata;

  // Request comes from another device: three flops, change counted on agree
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= dma_request_in;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  always_comb begin
    next_req_seen = req_seen;
    if (req_s2 == req_s3) begin
      next_req_seen = req_s3;
    end
  end

  function automatic logic [3:0] field_len(input logic [2:0] f);
    field_len = 4'(f) + 4'(dma_strobe_pkg::COUNT_BASE);
  endfunction

  always_comb begin
    next_state = state;
    next_timing = timing;
    next_count = count;
    next_extra = extra;
    next_strobe = strobe;
    next_drive = drive;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_is_write = is_write;
    next_wdata = write_data_in;
    case (state)
      dma_strobe_pkg::ST_IDLE: begin
        if (req_seen) begin
          next_timing.delay_long =
            dma_timing_register_in[dma_strobe_pkg::DELAY_SEL_BIT];
          next_timing.low_count =
            dma_timing_register_in[dma_strobe_pkg::LOW_LSB +: 3];
          next_timing.high_count =
            dma_timing_register_in[dma_strobe_pkg::HIGH_LSB +: 3];
          next_is_write = write_dir_in;
          next_count = 4'(dma_strobe_pkg::ACK_LEAD_CYCLES - 1);
          next_state = dma_strobe_pkg::ST_LEAD;
        end
      end
      dma_strobe_pkg::ST_LEAD: begin
        if (count == 4'h0) begin
          next_count = timing.delay_long ?
            4'(dma_strobe_pkg::DELAY_LONG) : 4'(dma_strobe_pkg::DELAY_SHORT);
          next_state = dma_strobe_pkg::ST_DELAY;
        end else begin
          next_count = count - 4'h1;
        end
      end
      dma_strobe_pkg::ST_DELAY: begin
        next_drive = is_write;
        if (time_tick_in) begin
          if (count == 4'h1) begin
            next_strobe = 1'b1;
            next_count = field_len(timing.low_count);
            // Sync lag can hide a drop for one strobe, so budget one less
            next_extra = 2'(dma_strobe_pkg::EXTRA_BURST_MAX - 1);
            next_state = dma_strobe_pkg::ST_LOW;
          end else begin
            next_count = count - 4'h1;
          end
        end
      end
      dma_strobe_pkg::ST_LOW: begin
        if (time_tick_in) begin
          if (count == 4'h1) begin
            next_strobe = 1'b0;
            next_rdata = data_bus_in;
            next_rvalid = !is_write;
            next_count = field_len(timing.high_count);
            next_state = dma_strobe_pkg::ST_HIGH;
          end else begin
            next_count = count - 4'h1;
          end
        end
      end
      dma_strobe_pkg::ST_HIGH: begin
        if (time_tick_in) begin
          if (count == 4'h1) begin
            // at most two extra strobes after request drops
            if (burst_mode_in && (req_seen || extra != 2'h0)) begin
              if (!req_seen) begin
                next_extra = extra - 2'h1;
              end
              next_strobe = 1'b1;
              next_count = field_len(timing.low_count);
              next_state = dma_strobe_pkg::ST_LOW;
            end else begin
              next_count = 4'(dma_strobe_pkg::ACK_TAIL_CYCLES);
              next_state = dma_strobe_pkg::ST_TAIL;
            end
          end else begin
            next_count = count - 4'h1;
          end
        end
      end
      dma_strobe_pkg::ST_TAIL: begin
        if (count == 4'h1) begin
          next_drive = 1'b0;
          next_state = dma_strobe_pkg::ST_IDLE;
        end else begin
          next_count = count - 4'h1;
        end
      end
      default: begin
        next_state = dma_strobe_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= dma_strobe_pkg::ST_IDLE;
      timing <= dma_strobe_pkg::strobe_timing_t'(7'h00);
      count <= 4'h0;
      extra <= 2'h0;
      req_seen <= 1'b0;
      strobe <= 1'b0;
      drive <= 1'b0;
      rdata <= '0;
      rvalid <= 1'b0;
      is_write <= 1'b0;
      wdata <= '0;
    end else begin
      state <= next_state;
      timing <= next_timing;
      count <= next_count;
      extra <= next_extra;
      req_seen <= next_req_seen;
      strobe <= next_strobe;
      drive <= next_drive;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      is_write <= next_is_write;
      wdata <= next_wdata;
    end
  end

  logic ack;
  assign ack = (state == dma_strobe_pkg::ST_DELAY) ||
               (state == dma_strobe_pkg::ST_LOW) ||
               (state == dma_strobe_pkg::ST_HIGH) ||
               (state == dma_strobe_pkg::ST_TAIL);
  // acknowledge drops with the bus released in the same cycle
  assign dma_acknowledge_out = ack;
  assign dma_read_strobe_n_out = !(strobe && !is_write);
  assign dma_write_strobe_n_out = !(strobe && is_write);
  assign data_bus_out = wdata;
  assign data_bus_oe_out = drive && ack;
  assign read_data_out = rdata;
  assign read_valid_out = rvalid;

  // Helper count of ticks while strobe is high
  logic [3:0] hi_ticks;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hi_ticks <= 4'h0;
    end else if (!strobe) begin
      hi_ticks <= 4'h0;
    end else if (time_tick_in) begin
      hi_ticks <= hi_ticks + 4'h1;
    end
  end

  a_ack_lead: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    $rose(ack) |-> $past(state) == dma_strobe_pkg::ST_LEAD)
    else $error("acknowledge without lead");
  a_strobe_gap: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    $rose(ack) |-> !strobe [*2])
    else $error("strobe too soon after acknowledge");
  a_strobe_width: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    $fell(strobe) |-> $past(hi_ticks) <= 4'h9)
    else $error("strobe width too long");
  a_strobe_in_ack: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    strobe |-> ack)
    else $error("strobe outside acknowledge");
  a_ack_tail: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    $fell(strobe) && state == dma_strobe_pkg::ST_HIGH |-> ack [*2])
    else $error("acknowledge dropped early");
  a_bus_release: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    !ack |-> !data_bus_oe_out)
    else $error("bus driven without acknowledge");
  a_timing_held: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    ack && $past(ack) |-> $stable(timing))
    else $error("timing changed in transfer");
  a_extra_limit: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    extra <= 2'h2)
    else $error("too many extra strobes");
  c_write: cover property (@(posedge clk_sys_in) $rose(data_bus_oe_out));
  c_read: cover property (@(posedge clk_sys_in) read_valid_out);
  c_burst: cover property (@(posedge clk_sys_in)
    state == dma_strobe_pkg::ST_HIGH ##1 state == dma_strobe_pkg::ST_LOW);
endmodule

// [dma_slave_model.sv]
// DMA slave model for the host-port strobe master.
// Assumes one clock; start_in asks for a transfer of words_in strobes when burst_in is set, of one strobe otherwise.
`timescale 1ns/1ps
module dma_slave_model (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic start_in,
  input wire logic burst_in,
  input wire logic [3:0] words_in,
  input wire logic [15:0] seed_in,
  input wire logic dma_acknowledge_in,
  input wire logic dma_read_strobe_n_in,
  input wire logic dma_write_strobe_n_in,
  output logic dma_request_out,
  output logic [15:0] data_bus_out
);
  logic [3:0] left;
  logic [15:0] word;
  logic strobe_q;
  logic strobe_n;
  assign strobe_n = dma_read_strobe_n_in & dma_write_strobe_n_in;
  // Pulled-up bus reads all ones whenever the slave is not driving
  assign data_bus_out = dma_read_strobe_n_in ? 16'hFFFF : word;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dma_request_out <= 1'b0;
      left <= 4'h0;
      word <= 16'h0000;
      strobe_q <= 1'b1;
    end else begin
      strobe_q <= strobe_n;
      // request only once acknowledge is low
      if (start_in && !dma_acknowledge_in) begin
        dma_request_out <= 1'b1;
        left <= words_in;
        word <= seed_in;
      end
      if (!burst_in && dma_acknowledge_in) begin
        dma_request_out <= 1'b0;
      end
      // burst request drops at last wanted strobe edge
      if (strobe_q && !strobe_n) begin
        left <= left - 4'h1;
        if (left == 4'h1) begin
          dma_request_out <= 1'b0;
        end
      end
      if (!strobe_q && strobe_n) begin
        word <= word + 16'h0001;
      end
    end
  end
endmodule

// [testbench.sv]
// Self-checking bench for the DMA strobe master against a slave model.
// Assumes the tick runs at full or half rate, chosen per transfer.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [4:0] a;
    logic [4:0] b;
    logic [4:0] i;
    logic [4:0] n;
  } exp_t;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] timing = 8'h00;
  logic burst = 1'b0;
  logic write_dir = 1'b0;
  logic start = 1'b0;
  logic [3:0] words = 4'h1;
  logic [15:0] seed = 16'h0000;
  logic [15:0] write_data = 16'h0000;
  logic [15:0] bus_i, bus_o, rdata, last_rd;
  logic req, ack, rs_n, ws_n, oe, rvalid, ack_q, st_q;
  logic [7:0] rnd = 8'h24;
  logic tick = 1'b1;
  logic half = 1'b0;
  int num_errors = 0;
  int checked = 0;
  int cnt, n_str;
  exp_t cur;
  exp_t q[$];
  always #25 clk_sys = ~clk_sys;
  // master time base: full rate or every other cycle
  always @(posedge clk_sys) begin
    #5;
    tick = half ? ~tick : 1'b1;
  end
  dma_strobe_master uut (.clk_sys_in(clk_sys), .arst_n_in(arst_n),
    .dma_timing_register_in(timing), .burst_mode_in(burst),
    .write_dir_in(write_dir), .time_tick_in(tick), .dma_request_in(req),
    .write_data_in(write_data), .data_bus_in(bus_i),
    .dma_acknowledge_out(ack), .dma_read_strobe_n_out(rs_n),
    .dma_write_strobe_n_out(ws_n), .data_bus_out(bus_o),
    .data_bus_oe_out(oe), .read_data_out(rdata), .read_valid_out(rvalid));
  dma_slave_model slave (.clk_sys_in(clk_sys), .arst_n_in(arst_n),
    .start_in(start), .burst_in(burst), .words_in(words), .seed_in(seed),
    .dma_acknowledge_in(ack), .dma_read_strobe_n_in(rs_n),
    .dma_write_strobe_n_in(ws_n), .dma_request_out(req),
    .data_bus_out(bus_i));
  function automatic logic [7:0] next_rand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_ack(input logic lvl);
    int w;
    for (w = 0; w < 300 && ack !== lvl; w++) @(posedge clk_sys);
    chk("ack_wait", 16'(lvl), 16'(ack));
  endtask
  // Sweeps every low count, both modes, both directions
  task automatic run(input logic [4:0] k);
    exp_t e;
    @(posedge clk_sys);
    #5;
    rnd = next_rand(rnd);
    timing = {1'b0, rnd[6], rnd[5:3], k[2:0]};
    burst = k[3];
    write_dir = k[0] ^ k[4];
    words = {2'b00, rnd[1:0]} + 4'h1;
    seed = {rnd, ~rnd};
    write_data = {~rnd, rnd};
    half = rnd[7];
    e.a = ({2'b00, k[2:0]} + 5'h02) << rnd[7];
    e.b = ({2'b00, rnd[5:3]} + 5'h02) << rnd[7];
    e.i = (rnd[6] ? 5'h04 : 5'h02) << rnd[7];
    e.n = k[3] ? {1'b0, words} : 5'h01;
    q.push_back(e);
    start = 1'b1;
    @(posedge clk_sys);
    #5;
    start = 1'b0;
    wait_ack(1'b1);
    #5;
    timing = ~timing;
    wait_ack(1'b0);
    repeat (3) @(posedge clk_sys);
  endtask
  always @(negedge clk_sys) begin
    ack_q <= ack;
    st_q <= rs_n & ws_n;
    cnt++;
    if (arst_n && ack === 1'b1 && ack_q !== 1'b1) begin
      cur = q.pop_front();
      // A tick right after acknowledge shortens the lead by one cycle
      cur.i = cur.i - 5'(half & tick);
      cnt = 0;
      n_str = 0;
    end
    if (arst_n && st_q === 1'b1 && (rs_n & ws_n) === 1'b0) begin
      chk("strobe_lead", n_str ? cur.b : cur.i, 16'(cnt));
      n_str++;
      cnt = 0;
    end
    if (arst_n && st_q === 1'b0 && (rs_n & ws_n) === 1'b1) begin
      chk("strobe_width", cur.a, 16'(cnt));
      cnt = 0;
    end
    if (arst_n && ack === 1'b0 && ack_q === 1'b1) begin
      chk("strobes_min", 16'h1, 16'(n_str >= cur.n));
      chk("strobes_max", 16'h1, 16'(n_str <= cur.n + 2));
    end
    if (rs_n === 1'b0) last_rd = bus_i;
    if (rvalid === 1'b1) chk("read_data", last_rd, rdata);
    if (ws_n === 1'b0) chk("write_bus", write_data, oe ? bus_o : ~bus_o);
    if (arst_n && ack === 1'b0) chk("bus_release", 16'h0, 16'(oe));
  end
  initial begin
    #(50 * 30000);
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    #5;
    arst_n = 1'b1;
    for (int k = 0; k < 32; k++) run(5'(k));
    finish_test();
  end
endmodule
